/* File: src/ipvs_cfg.svh */
`ifndef IPVS_CFG_SVH
`define IPVS_CFG_SVH
// Register byte offsets.
`define IPVS_OFF_PRIO15   12'h000
`define IPVS_OFF_PRIO16   12'h004
`define IPVS_OFF_PRIO17   12'h008
`define IPVS_OFF_STATUS   12'h00c
`define IPVS_OFF_CTRL     12'h010
`define IPVS_OFF_FLAGS    12'h014
`define IPVS_OFF_ENABLES  12'h018
`define IPVS_OFF_EVT_STAT 12'h01c
`define IPVS_OFF_EVT_MASK 12'h020
`define IPVS_OFF_RUN      12'h024
// Implemented bits and reset values of the priority registers.
`define IPVS_PRIO15_MASK  16'h0770
`define IPVS_PRIO16_MASK  16'h7770
`define IPVS_PRIO17_MASK  16'h0777
`define IPVS_PRIO15_RST   16'h0440
`define IPVS_PRIO16_RST   16'h4440
`define IPVS_PRIO17_RST   16'h0444
// Control register fields.
`define IPVS_CTRL_NEST_BIT 15
`define IPVS_CTRL_TRAP_W   4
// Status register fields.
`define IPVS_STAT_LVL_LSB  8
`define IPVS_VEC_OFFSET    8
// Vector of source 0; source i uses this plus i.
`define IPVS_VEC_BASE      7'd50
`define IPVS_NSRC          8
`define IPVS_CAN_SRC       5
`define IPVS_STACK_DEPTH   8
// Event status bits.
`define IPVS_EVT_ACK       0
`define IPVS_EVT_RET       1
`define IPVS_EVT_TRAP      2
`define IPVS_EVT_UNDER     3
`define IPVS_EVT_OVER      4
`define IPVS_EVT_W         5
`endif

/* File: src/ipvs_pkg.sv */
package ipvs_pkg;
   typedef struct packed {
      logic       valid;
      logic [3:0] level;
      logic [6:0] vec_idx;
   } ipvs_pend_t;
   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } ipvs_apb_req_t;
endpackage

/* File: src/ipvs_top.sv */
// Summary of operation
// - Field 7..1 is priority; 0 disables source.
// - Reset puts every source at priority 4.
// - Unimplemented bits ignore writes, read zero.
// - Status bits 11-8 show new CPU level.
// - Status bits 6-0 show vector minus eight.
// - Control bit 15 blocks nested preemption.
// - Set, enabled flag keeps requesting until cleared.
// - Return restores previous CPU level from stack, unless an ack is taken in the same cycle.
// - Trap flag keeps trap request until cleared.
// - Register fifteen: clock bits 10-8, DMA5 6-4.
// - Register seventeen: CAN 10-8, DMA7 6-4, DMA6 2-0.
// - Without CAN, transmit source is always disabled.
`include "ipvs_cfg.svh"
module ipvs_top
   import ipvs_pkg::*;
#(
   parameter bit HAS_CAN = 1'b1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  src_event,
   input  wire logic [3:0]  trap_event,
   input  wire logic        cpu_ack,
   input  wire logic        cpu_return,
   output logic             cpu_irq_req,
   output logic      [3:0]  cpu_irq_level,
   output logic      [6:0]  cpu_irq_vector,
   output logic             trap_req,
   output logic             irq
);
   localparam int NS = `IPVS_NSRC;
   localparam int SD = `IPVS_STACK_DEPTH;

   logic [15:0] prio15_reg;
   logic [15:0] prio16_reg;
   logic [15:0] prio17_reg;
   logic        nest_dis_reg;
   logic [3:0]  trap_reg;
   logic [7:0]  flag_reg;
   logic [7:0]  en_reg;
   logic [4:0]  evt_reg;
   logic [4:0]  mask_reg;
   logic [3:0]  run_level_reg;
   logic [3:0]  depth_reg;
   logic [3:0]  stack_mem [SD];
   logic [31:0] prdata_reg;
   logic        req_reg;
   logic [3:0]  lvl_reg;
   logic [6:0]  vec_reg;

   ipvs_apb_req_t bus;
   assign bus = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

   // Bus decode.
   wire setup_rd  = pce && bus.sel && !bus.enable && !bus.write;
   wire access    = pce && bus.sel && bus.enable;
   wire wr        = access && bus.write;
   wire rd_acc    = access && !bus.write;
   wire hit_p15   = bus.addr == `IPVS_OFF_PRIO15;
   wire hit_p16   = bus.addr == `IPVS_OFF_PRIO16;
   wire hit_p17   = bus.addr == `IPVS_OFF_PRIO17;
   wire hit_stat  = bus.addr == `IPVS_OFF_STATUS;
   wire hit_ctrl  = bus.addr == `IPVS_OFF_CTRL;
   wire hit_flag  = bus.addr == `IPVS_OFF_FLAGS;
   wire hit_en    = bus.addr == `IPVS_OFF_ENABLES;
   wire hit_evt   = bus.addr == `IPVS_OFF_EVT_STAT;
   wire hit_mask  = bus.addr == `IPVS_OFF_EVT_MASK;
   wire hit_run   = bus.addr == `IPVS_OFF_RUN;
   wire hit_any   = hit_p15 | hit_p16 | hit_p17 | hit_stat | hit_ctrl | hit_flag
                  | hit_en | hit_evt | hit_mask | hit_run;

   assign pready  = 1'b1;
   assign pslverr = bus.sel && bus.enable && !hit_any;

   // Per-source priority fields, in ascending vector order.
   logic [2:0] prio [NS];
   assign prio[0] = prio15_reg[10:8];
   assign prio[1] = prio15_reg[6:4];
   assign prio[2] = prio16_reg[14:12];
   assign prio[3] = prio16_reg[10:8];
   assign prio[4] = prio16_reg[6:4];
   assign prio[5] = prio17_reg[10:8];
   assign prio[6] = prio17_reg[6:4];
   assign prio[7] = prio17_reg[2:0];

   logic [NS-1:0] active;
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_act
         // A zero field disables the source; the CAN source is dead without CAN.
         if (gi == `IPVS_CAN_SRC) begin : g_can
            assign active[gi] = flag_reg[gi] && en_reg[gi] && (prio[gi] != 3'h0)
                              && HAS_CAN;
         end else begin : g_std
            assign active[gi] = flag_reg[gi] && en_reg[gi] && (prio[gi] != 3'h0);
         end
      end
   endgenerate

   // Highest level wins; strict compare keeps the lower vector on a tie.
   ipvs_pend_t pend;
   always_comb begin
      pend = '0;
      for (int i = 0; i < NS; i++) begin
         if (active[i] && (!pend.valid || {1'b0, prio[i]} > pend.level)) begin
            pend.valid   = 1'b1;
            pend.level   = {1'b0, prio[i]};
            pend.vec_idx = `IPVS_VEC_BASE + 7'(i) - 7'(`IPVS_VEC_OFFSET);
         end
      end
   end

   wire nest_block = nest_dis_reg && (depth_reg != 4'h0);
   wire req_next   = pend.valid && (pend.level > run_level_reg) && !nest_block;
   wire take       = pce && cpu_ack && req_reg && (depth_reg != 4'(SD));
   wire overflow   = pce && cpu_ack && req_reg && (depth_reg == 4'(SD));
   wire pop        = pce && cpu_return && (depth_reg != 4'h0) && !take;
   wire underflow  = pce && cpu_return && (depth_reg == 4'h0);
   wire [3:0] top_level = stack_mem[3'(depth_reg - 4'h1)];

   wire [15:0] stat_word = {4'h0, lvl_reg, 1'b0, vec_reg};
   wire [15:0] ctrl_word = {nest_dis_reg, 11'h000, trap_reg};
   wire [15:0] run_word  = {8'h00, depth_reg, run_level_reg};

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_p15)  rd_mux = {16'h0000, prio15_reg};
      if (hit_p16)  rd_mux = {16'h0000, prio16_reg};
      if (hit_p17)  rd_mux = {16'h0000, prio17_reg};
      if (hit_stat) rd_mux = {16'h0000, stat_word};
      if (hit_ctrl) rd_mux = {16'h0000, ctrl_word};
      if (hit_flag) rd_mux = {24'h000000, flag_reg};
      if (hit_en)   rd_mux = {24'h000000, en_reg};
      if (hit_evt)  rd_mux = {27'h0000000, evt_reg};
      if (hit_mask) rd_mux = {27'h0000000, mask_reg};
      if (hit_run)  rd_mux = {16'h0000, run_word};
   end

   // Event bits: a read clears only the bits it returned, so an event that lands
   // between setup and access is kept; a new event in the same cycle wins.
   logic [4:0] evt_set;
   assign evt_set[`IPVS_EVT_ACK]   = take;
   assign evt_set[`IPVS_EVT_RET]   = pop;
   assign evt_set[`IPVS_EVT_TRAP]  = pce && (trap_event != 4'h0);
   assign evt_set[`IPVS_EVT_UNDER] = underflow;
   assign evt_set[`IPVS_EVT_OVER]  = overflow;
   wire [4:0] evt_next = ((rd_acc && hit_evt) ? (evt_reg & ~prdata_reg[4:0]) : evt_reg)
                       | evt_set;

   // Flags are software read/write; a hardware event beats a clearing write.
   wire [7:0] flag_next = ((wr && hit_flag) ? pwdata[7:0] : flag_reg)
                        | (pce ? src_event : 8'h00);
   wire [3:0] trap_next = ((wr && hit_ctrl) ? pwdata[3:0] : trap_reg)
                        | (pce ? trap_event : 4'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio15_reg <= `IPVS_PRIO15_RST;
         prio16_reg <= `IPVS_PRIO16_RST;
         prio17_reg <= `IPVS_PRIO17_RST;
         nest_dis_reg <= 1'b0;
         en_reg <= 8'h00;
         mask_reg <= 5'h00;
      end else if (wr) begin
         if (hit_p15) prio15_reg <= pwdata[15:0] & `IPVS_PRIO15_MASK;
         if (hit_p16) prio16_reg <= pwdata[15:0] & `IPVS_PRIO16_MASK;
         if (hit_p17) prio17_reg <= pwdata[15:0] & `IPVS_PRIO17_MASK;
         if (hit_ctrl) nest_dis_reg <= pwdata[`IPVS_CTRL_NEST_BIT];
         if (hit_en) en_reg <= pwdata[7:0];
         if (hit_mask) mask_reg <= pwdata[4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= 8'h00;
         trap_reg <= 4'h0;
         evt_reg <= 5'h00;
      end else begin
         flag_reg <= flag_next;
         trap_reg <= trap_next;
         evt_reg <= evt_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup_rd) begin
         prdata_reg <= rd_mux;
      end
   end

   // Saved CPU levels; a return pops the level that was running before.
   always_ff @(posedge pclk) begin
      if (take) begin
         stack_mem[3'(depth_reg)] <= run_level_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_level_reg <= 4'h0;
         depth_reg <= 4'h0;
      end else if (take) begin
         run_level_reg <= lvl_reg;
         depth_reg <= depth_reg + 4'h1;
      end else if (pop) begin
         run_level_reg <= top_level;
         depth_reg <= depth_reg - 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg <= 1'b0;
         lvl_reg <= 4'h0;
         vec_reg <= 7'h00;
      end else if (pce) begin
         req_reg <= req_next && !take && !pop;
         lvl_reg <= pend.level;
         vec_reg <= pend.vec_idx;
      end
   end

   assign prdata         = prdata_reg;
   assign cpu_irq_req    = req_reg;
   assign cpu_irq_level  = lvl_reg;
   assign cpu_irq_vector = vec_reg;
   assign trap_req       = trap_reg != 4'h0;
   assign irq            = (evt_reg & mask_reg) != 5'h00;

   // Checks.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic better_exists;
   always_comb begin
      better_exists = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (active[i] && {1'b0, prio[i]} > pend.level) begin
            better_exists = 1'b1;
         end
         if (active[i] && {1'b0, prio[i]} == pend.level
             && (`IPVS_VEC_BASE + 7'(i) - 7'(`IPVS_VEC_OFFSET)) < pend.vec_idx) begin
            better_exists = 1'b1;
         end
      end
   end

   property p_unimpl_zero;
      ((prio15_reg & ~`IPVS_PRIO15_MASK) == 16'h0) && ((prio16_reg & ~`IPVS_PRIO16_MASK) == 16'h0)
         && ((prio17_reg & ~`IPVS_PRIO17_MASK) == 16'h0) && (stat_word[15:12] == 4'h0);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bit is set.");

   property p_zero_disables;
      pend.valid |-> pend.level != 4'h0;
   endproperty
   a_zero_disables: assert property (p_zero_disables) else $error("Disabled source won.");

   property p_level_out;
      pce |=> cpu_irq_level == $past(pend.level);
   endproperty
   a_level_out: assert property (p_level_out) else $error("Level field is wrong.");

   property p_vector_out;
      pce && pend.valid |=> cpu_irq_vector + 7'(`IPVS_VEC_OFFSET) == $past(pend.vec_idx) + 7'd8;
   endproperty
   a_vector_out: assert property (p_vector_out) else $error("Vector field is wrong.");

   property p_nest_block;
      pce && nest_dis_reg && depth_reg != 4'h0 |=> !cpu_irq_req;
   endproperty
   a_nest_block: assert property (p_nest_block) else $error("Nested request raised.");

   property p_keep_request;
      !(wr && hit_flag) |=> (flag_reg & $past(flag_reg)) == $past(flag_reg);
   endproperty
   a_keep_request: assert property (p_keep_request) else $error("Pending source lost.");

   property p_return_level;
      pop |=> run_level_reg == $past(top_level) && depth_reg == $past(depth_reg) - 4'h1;
   endproperty
   a_return_level: assert property (p_return_level) else $error("Return level wrong.");

   property p_trap_hold;
      trap_reg != 4'h0 && !(wr && hit_ctrl) |=> trap_req [*1];
   endproperty
   a_trap_hold: assert property (p_trap_hold) else $error("Trap request dropped.");

   property p_no_can;
      !HAS_CAN |-> !active[`IPVS_CAN_SRC];
   endproperty
   a_no_can: assert property (p_no_can) else $error("CAN source active.");

   property p_best_wins;
      !better_exists;
   endproperty
   a_best_wins: assert property (p_best_wins) else $error("Wrong source chosen.");

   property p_reset_prio;
      $rose(presetn) |-> prio[0] == 3'h4 && prio[7] == 3'h4;
   endproperty
   a_reset_prio: assert property (p_reset_prio) else $error("Reset priority wrong.");

   property p_cov_ack;
      take;
   endproperty
   c_cov_ack: cover property (p_cov_ack);
   property p_cov_nested;
      take && depth_reg == 4'h1;
   endproperty
   c_cov_nested: cover property (p_cov_nested);
   property p_cov_return;
      pop ##1 cpu_irq_req;
   endproperty
   c_cov_return: cover property (p_cov_return);
   property p_cov_trap;
      trap_req && irq;
   endproperty
   c_cov_trap: cover property (p_cov_trap);
endmodule

/* File: tb/ipvs_cpu_model.sv */
module ipvs_cpu_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cpu_irq_req,
   input  wire logic       ack_en,
   input  wire logic [3:0] lat,
   input  wire logic       ret_go,
   output logic            cpu_ack,
   output logic            cpu_return
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   // The core takes a request only after it has stood for lat+1 cycles.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt        <= 4'h0;
         cpu_ack    <= 1'b0;
         cpu_return <= 1'b0;
      end else begin
         cpu_ack    <= 1'b0;
         cpu_return <= ret_go;
         if (ack_en && cpu_irq_req && !cpu_ack) begin
            if (cnt == lat) begin
               cpu_ack <= 1'b1;
               cnt     <= 4'h0;
            end else begin
               cnt <= cnt + 4'h1;
            end
         end else begin
            cnt <= 4'h0;
         end
      end
   end
endmodule

/* File: tb/tb_top.sv */
`include "ipvs_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, cpu_ack, cpu_return, cpu_irq_req;
   logic        trap_req, irq, ack_en = 1'b0, ret_go = 1'b0, rde;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdq;
   logic [7:0]  src_event = 8'h00;
   logic [3:0]  trap_event = 4'h0, cpu_irq_level;
   logic [6:0]  cpu_irq_vector;
   logic [3:0]  nc_level;
   logic [6:0]  nc_vector;
   int          error_cnt = 0, checks_done = 0;
   always #2 pclk = ~pclk;
   ipvs_top #(.HAS_CAN(1'b1)) uut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_event(src_event), .trap_event(trap_event),
      .cpu_ack(cpu_ack), .cpu_return(cpu_return), .cpu_irq_req(cpu_irq_req),
      .cpu_irq_level(cpu_irq_level), .cpu_irq_vector(cpu_irq_vector),
      .trap_req(trap_req), .irq(irq));
   ipvs_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req),
      .ack_en(ack_en), .lat(4'h2), .ret_go(ret_go), .cpu_ack(cpu_ack), .cpu_return(cpu_return));
   // A second copy built without CAN shares the bus and events.
   ipvs_top #(.HAS_CAN(1'b0)) uut_nocan (.pclk(pclk), .presetn(presetn), .pce(pce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .src_event(src_event), .trap_event(trap_event),
      .cpu_ack(1'b0), .cpu_return(1'b0), .cpu_irq_req(), .cpu_irq_level(nc_level),
      .cpu_irq_vector(nc_vector), .trap_req(), .irq());
   task print_verdict;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         print_verdict();
      end
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wait_req(input logic v);
      int n;
      n = 0;
      while (cpu_irq_req !== v && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (cpu_irq_req !== v) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   task ev(input logic [7:0] m);
      src_event <= m;
      @(posedge pclk);
      src_event <= 8'h00;
   endtask
   task t_regs;
      apb(`IPVS_OFF_PRIO15, 0, 0); chk("prio15_rst", rdq, 32'h0440);
      apb(`IPVS_OFF_PRIO16, 0, 0); chk("prio16_rst", rdq, 32'h4440);
      apb(`IPVS_OFF_PRIO17, 0, 0); chk("prio17_rst", rdq, 32'h0444);
      apb(`IPVS_OFF_STATUS, 0, 0); chk("status_rst", rdq, 32'h0);
      apb(`IPVS_OFF_PRIO15, 1, '1); apb(`IPVS_OFF_PRIO15, 0, 0);
      chk("prio15_ones", rdq, 32'h0770);
      apb(`IPVS_OFF_PRIO16, 1, '1); apb(`IPVS_OFF_PRIO16, 0, 0);
      chk("prio16_ones", rdq, 32'h7770);
      apb(`IPVS_OFF_PRIO17, 1, '1); apb(`IPVS_OFF_PRIO17, 0, 0);
      chk("prio17_ones", rdq, 32'h0777);
      apb(`IPVS_OFF_STATUS, 1, '1); apb(`IPVS_OFF_STATUS, 0, 0);
      chk("status_ro", rdq, 32'h0);
      apb(12'h0fc, 0, 0); chk("unmapped_err", {rde, rdq[30:0]}, 32'h80000000);
   endtask
   task t_arbit;
      apb(`IPVS_OFF_PRIO17, 1, 32'h0055);
      apb(`IPVS_OFF_FLAGS, 1, 0);
      apb(`IPVS_OFF_ENABLES, 1, 32'he0);
      ev(8'he0);
      wait_req(1);
      apb(`IPVS_OFF_STATUS, 0, 0); chk("tie_lower_vec", rdq, 32'h0530);
      apb(`IPVS_OFF_PRIO17, 1, 32'h0005);
      apb(`IPVS_OFF_STATUS, 0, 0); chk("zero_disables", rdq, 32'h0531);
      apb(`IPVS_OFF_PRIO17, 1, 32'h0754);
      apb(`IPVS_OFF_STATUS, 0, 0); chk("can_highest", rdq, 32'h072f);
      chk("no_can_pending", {20'h0, nc_level, 1'b0, nc_vector}, 32'h0530);
      apb(`IPVS_OFF_FLAGS, 1, 0);
      apb(`IPVS_OFF_ENABLES, 1, 0);
      repeat (3) @(posedge pclk);
      apb(`IPVS_OFF_STATUS, 0, 0); chk("status_idle", rdq, 32'h0);
   endtask
   task t_service;
      apb(`IPVS_OFF_EVT_MASK, 1, 32'h3);
      apb(`IPVS_OFF_PRIO15, 1, 32'h0600);
      apb(`IPVS_OFF_FLAGS, 1, 0);
      apb(`IPVS_OFF_ENABLES, 1, 32'h01);
      ev(8'h01);
      wait_req(1);
      chk("req_level", cpu_irq_level, 32'h6);
      chk("req_vector", cpu_irq_vector, 32'd42);
      ack_en <= 1'b1;
      wait_req(0);
      ack_en <= 1'b0;
      apb(`IPVS_OFF_RUN, 0, 0); chk("run_after_ack", rdq, 32'h16);
      apb(`IPVS_OFF_CTRL, 1, 32'h8000);
      apb(`IPVS_OFF_PRIO15, 1, 32'h0670);
      apb(`IPVS_OFF_ENABLES, 1, 32'h03);
      ev(8'h02);
      repeat (4) @(posedge pclk);
      chk("nest_blocked", cpu_irq_req, 32'h0);
      apb(`IPVS_OFF_CTRL, 1, 0);
      wait_req(1);
      chk("nest_level", cpu_irq_level, 32'h7);
      apb(`IPVS_OFF_FLAGS, 1, 32'h01);
      repeat (4) @(posedge pclk);
      chk("no_reenter_same", cpu_irq_req, 32'h0);
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
      wait_req(1);
      chk("reenter_level", cpu_irq_level, 32'h6);
      apb(`IPVS_OFF_RUN, 0, 0); chk("run_after_ret", rdq, 32'h0);
      chk("irq_raised", irq, 32'h1);
      apb(`IPVS_OFF_EVT_STAT, 0, 0); chk("events", rdq, 32'h3);
      @(posedge pclk);
      chk("irq_cleared", irq, 32'h0);
      apb(`IPVS_OFF_FLAGS, 1, 0);
      repeat (4) @(posedge pclk);
      chk("req_after_clear", cpu_irq_req, 32'h0);
      apb(`IPVS_OFF_ENABLES, 1, 0);
   endtask
   task t_trap;
      pce <= 1'b0;
      trap_event <= 4'h4;
      @(posedge pclk);
      pce <= 1'b1;
      trap_event <= 4'h0;
      @(posedge pclk);
      chk("trap_frozen", trap_req, 32'h0);
      @(posedge pclk);
      trap_event <= 4'h4;
      @(posedge pclk);
      trap_event <= 4'h0;
      repeat (3) @(posedge pclk);
      chk("trap_req", trap_req, 32'h1);
      chk("trap_masked", irq, 32'h0);
      apb(`IPVS_OFF_CTRL, 0, 0); chk("trap_flag", rdq, 32'h0004);
      repeat (5) @(posedge pclk);
      chk("trap_holds", trap_req, 32'h1);
      apb(`IPVS_OFF_CTRL, 1, 32'h8000);
      repeat (3) @(posedge pclk);
      chk("trap_cleared", trap_req, 32'h0);
      apb(`IPVS_OFF_CTRL, 0, 0); chk("nest_bit", rdq, 32'h8000);
      ret_go <= 1'b1;
      @(posedge pclk);
      ret_go <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(`IPVS_OFF_EVT_STAT, 0, 0); chk("underflow_evt", rdq, 32'h000c);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_arbit();
      t_service();
      t_trap();
      print_verdict();
   end
endmodule
